//--- verilog/energy_minmax_pkg.sv
/*
 * Constants, command codes, reset values and carrier types shared by the
 * energy, min-tracker and hysteresis command bank.
 * Assumes a PMBus front end outside that decodes command codes and byte counts.
 */
package energy_minmax_pkg;

    localparam logic [7:0] CMD_EXT_INPUT_POWER = 8'hDB;
    localparam logic [7:0] CMD_FWD_ENERGY_EXT = 8'hDC;
    localparam logic [7:0] CMD_AUX_VOLTAGE = 8'hDD;
    localparam logic [7:0] CMD_AUX_OV_THRESH = 8'hDE;
    localparam logic [7:0] CMD_AUX_UV_THRESH = 8'hDF;
    localparam logic [7:0] CMD_MIN_OUT_CURRENT = 8'hE3;
    localparam logic [7:0] CMD_MIN_INPUT_POWER = 8'hE4;
    localparam logic [7:0] CMD_REV_ENERGY_EXT = 8'hE5;
    localparam logic [7:0] CMD_HYST_LOWER = 8'hF2;
    localparam logic [7:0] CMD_HYST_UPPER = 8'hF3;
    localparam logic [7:0] CMD_HYST_STATUS = 8'hF4;

    // Byte counts returned per command
    localparam logic [3:0] LEN_NONE = 4'h0;
    localparam logic [3:0] LEN_STATUS = 4'h1;
    localparam logic [3:0] LEN_WORD = 4'h2;
    localparam logic [3:0] LEN_POWER_EXT = 4'h3;
    localparam logic [3:0] LEN_ENERGY_EXT = 4'h8;

    localparam logic [23:0] RST_EXT_POWER = 24'h000000;
    localparam logic [11:0] RST_AUX_OV = 12'hFFF;
    localparam logic [11:0] RST_AUX_UV = 12'h000;
    localparam logic [15:0] RST_MIN_CURRENT = 16'h07FF;
    localparam logic [15:0] RST_MIN_POWER = 16'h7FFF;
    localparam logic [15:0] RST_HYST_LOWER = 16'h8000;
    localparam logic [15:0] RST_HYST_UPPER = 16'h7FFF;
    localparam logic [15:0] CLEAR_WORD = 16'h0000;

    localparam logic [23:0] ENERGY_ZERO = 24'h000000;
    localparam logic [15:0] WRAP_ZERO = 16'h0000;
    localparam logic [23:0] SAMPLES_ZERO = 24'h000000;

    // Extended energy layout
    localparam int ENERGY_LSB = 0;
    localparam int WRAP_LSB = 24;
    localparam int SAMPLES_LSB = 40;

    // Status layout
    localparam int ST_BELOW_LOWER = 0;
    localparam int ST_ABOVE_UPPER = 1;
    localparam int ST_HYST_LEVEL = 2;
    localparam int ST_OVERCURRENT = 3;

    typedef struct packed {
        logic [23:0] ext_input_power;
        logic [15:0] input_power;
        logic [15:0] output_current;
        logic [11:0] aux_voltage;
        logic [15:0] compared_value;
    } meas_s;

    typedef struct packed {
        logic [23:0] forward_inc;
        logic [23:0] reverse_inc;
    } energy_inc_s;

    typedef struct packed {
        logic [23:0] value;
        logic [15:0] wraps;
    } energy_acc_s;

endpackage : energy_minmax_pkg

//--- verilog/signed_min_tracker.sv
/*
 * Most-negative tracker for one signed measurement word.
 * Assumes samples and clear requests come from logic on the same clock.
 */
`timescale 1ns/1ps
module signed_min_tracker #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    input wire logic sample_valid_i,
    input wire logic [WIDTH-1:0] sample_i,
    output logic [WIDTH-1:0] min_o
);

    logic [WIDTH-1:0] min_q;
    logic [WIDTH-1:0] base;

    // A clear and a sample in one cycle: restart, then still take the sample
    always_comb begin
        base = clear_i ? RESET_VALUE : min_q;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            min_q <= RESET_VALUE;
        end else if (sample_valid_i && ($signed(sample_i) < $signed(base))) begin
            min_q <= sample_i;
        end else begin
            min_q <= base;
        end
    end

    assign min_o = min_q;

endmodule : signed_min_tracker

//--- verilog/energy_minmax_hysteresis_regs.sv
/*
 * Command bank for extended power, energy accumulators, aux voltage limits,
 * most-negative trackers and the hysteretic comparator.
 * Assumes a PMBus front end on the same clock that presents one decoded
 * command per strobe and serialises the returned word low byte first.
 */
`timescale 1ns/1ps
module energy_minmax_hysteresis_regs #(
    parameter bit SIGNED_ENERGY = 1'b0
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // Measurement side
    input wire logic meas_valid_i,
    input wire energy_minmax_pkg::meas_s meas_i,
    input wire logic energy_valid_i,
    input wire energy_minmax_pkg::energy_inc_s energy_inc_i,
    input wire logic overcurrent_warning_flag_i,
    // Command side
    input wire logic [7:0] cmd_code_i,
    input wire logic rd_stb_i,
    input wire logic wr_stb_i,
    input wire logic [15:0] wr_data_i,
    output logic rd_valid_o,
    output logic rd_unmapped_o,
    output logic [3:0] rd_len_o,
    output logic [63:0] rd_data_o,
    output logic wr_refused_o,
    // Derived outputs
    output logic hysteretic_output_level_o,
    output logic aux_ov_warn_o,
    output logic aux_uv_warn_o
);

    localparam logic [24:0] SIGNED_SPAN = 25'h0800000;
    localparam logic [24:0] SIGNED_MAX = 25'h07FFFFF;

    logic [23:0] ext_power_q;
    logic [11:0] aux_voltage_q;
    logic [11:0] aux_ov_q;
    logic [11:0] aux_uv_q;
    logic [15:0] hyst_lower_q;
    logic [15:0] hyst_upper_q;
    logic above_upper_flag_q;
    logic below_lower_flag_q;
    logic level_q;
    logic level_d;
    logic overcurrent_q;
    logic aux_ov_q_flag;
    logic aux_uv_q_flag;

    energy_minmax_pkg::energy_acc_s fwd_q;
    energy_minmax_pkg::energy_acc_s rev_q;
    energy_minmax_pkg::energy_acc_s fwd_d;
    energy_minmax_pkg::energy_acc_s rev_d;
    logic [23:0] samples_q;

    logic [15:0] min_current;
    logic [15:0] min_power;
    logic clr_min_current;
    logic clr_min_power;

    logic rd_valid_q;
    logic rd_unmapped_q;
    logic [3:0] rd_len_q;
    logic [63:0] rd_data_q;
    logic [63:0] rd_data_d;
    logic [3:0] rd_len_d;
    logic rd_hit_d;
    logic wr_refused_q;
    logic wr_ok;

    logic [7:0] status_byte;
    logic cmp_above;
    logic cmp_below;

    // Accumulate one increment and report a wrap of the visible range.
    // Signed variant wraps at 0x7FFFFF; increments there must stay below 2^23.
    function automatic energy_minmax_pkg::energy_acc_s accumulate(
        input energy_minmax_pkg::energy_acc_s acc,
        input logic [23:0] inc
    );
        logic [24:0] sum;
        energy_minmax_pkg::energy_acc_s res;
        sum = {1'b0, acc.value} + {1'b0, inc};
        res = acc;
        if (SIGNED_ENERGY) begin
            if (sum > SIGNED_MAX) begin
                res.value = 24'(sum - SIGNED_SPAN);
                res.wraps = acc.wraps + 16'h0001;
            end else begin
                res.value = sum[23:0];
            end
        end else begin
            res.value = sum[23:0];
            if (sum[24]) begin
                res.wraps = acc.wraps + 16'h0001;
            end
        end
        return res;
    endfunction : accumulate

    // Latest measurement words
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_power_q <= energy_minmax_pkg::RST_EXT_POWER;
            aux_voltage_q <= 12'h000;
        end else if (meas_valid_i) begin
            ext_power_q <= meas_i.ext_input_power;
            aux_voltage_q <= meas_i.aux_voltage;
        end
    end

    // Energy accumulators and shared sample count
    always_comb begin
        fwd_d = accumulate(fwd_q, energy_inc_i.forward_inc);
        rev_d = accumulate(rev_q, energy_inc_i.reverse_inc);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fwd_q <= '{value: energy_minmax_pkg::ENERGY_ZERO, wraps: energy_minmax_pkg::WRAP_ZERO};
            rev_q <= '{value: energy_minmax_pkg::ENERGY_ZERO, wraps: energy_minmax_pkg::WRAP_ZERO};
            samples_q <= energy_minmax_pkg::SAMPLES_ZERO;
        end else if (energy_valid_i) begin
            fwd_q <= fwd_d;
            rev_q <= rev_d;
            samples_q <= samples_q + 24'h000001;
        end
    end

    // Writable commands: thresholds and the two tracker clears
    always_comb begin
        wr_ok = 1'b0;
        case (cmd_code_i)
            energy_minmax_pkg::CMD_AUX_OV_THRESH,
            energy_minmax_pkg::CMD_AUX_UV_THRESH,
            energy_minmax_pkg::CMD_MIN_OUT_CURRENT,
            energy_minmax_pkg::CMD_MIN_INPUT_POWER,
            energy_minmax_pkg::CMD_HYST_LOWER,
            energy_minmax_pkg::CMD_HYST_UPPER: begin
                wr_ok = 1'b1;
            end
            default: begin
                wr_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aux_ov_q <= energy_minmax_pkg::RST_AUX_OV;
            aux_uv_q <= energy_minmax_pkg::RST_AUX_UV;
        end else if (wr_stb_i) begin
            if (cmd_code_i == energy_minmax_pkg::CMD_AUX_OV_THRESH) begin
                aux_ov_q <= wr_data_i[11:0];
            end
            if (cmd_code_i == energy_minmax_pkg::CMD_AUX_UV_THRESH) begin
                aux_uv_q <= wr_data_i[11:0];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hyst_lower_q <= energy_minmax_pkg::RST_HYST_LOWER;
            hyst_upper_q <= energy_minmax_pkg::RST_HYST_UPPER;
        end else if (wr_stb_i) begin
            if (cmd_code_i == energy_minmax_pkg::CMD_HYST_LOWER) begin
                hyst_lower_q <= wr_data_i;
            end
            if (cmd_code_i == energy_minmax_pkg::CMD_HYST_UPPER) begin
                hyst_upper_q <= wr_data_i;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_refused_q <= 1'b0;
        end else begin
            wr_refused_q <= wr_stb_i && !wr_ok;
        end
    end

    // Aux warnings; the default threshold values switch each one off
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aux_ov_q_flag <= 1'b0;
            aux_uv_q_flag <= 1'b0;
        end else begin
            aux_ov_q_flag <= (aux_ov_q != energy_minmax_pkg::RST_AUX_OV) &&
                (aux_voltage_q > aux_ov_q);
            aux_uv_q_flag <= (aux_uv_q != energy_minmax_pkg::RST_AUX_UV) &&
                (aux_voltage_q < aux_uv_q);
        end
    end

    // Minimum trackers; only a zero write clears, other writes are dropped
    always_comb begin
        clr_min_current = wr_stb_i && (wr_data_i == energy_minmax_pkg::CLEAR_WORD) &&
            (cmd_code_i == energy_minmax_pkg::CMD_MIN_OUT_CURRENT);
        clr_min_power = wr_stb_i && (wr_data_i == energy_minmax_pkg::CLEAR_WORD) &&
            (cmd_code_i == energy_minmax_pkg::CMD_MIN_INPUT_POWER);
    end

    signed_min_tracker #(
        .WIDTH(16),
        .RESET_VALUE(energy_minmax_pkg::RST_MIN_CURRENT)
    ) u_min_current (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .clear_i(clr_min_current),
        .sample_valid_i(meas_valid_i),
        .sample_i(meas_i.output_current),
        .min_o(min_current)
    );

    signed_min_tracker #(
        .WIDTH(16),
        .RESET_VALUE(energy_minmax_pkg::RST_MIN_POWER)
    ) u_min_power (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .clear_i(clr_min_power),
        .sample_valid_i(meas_valid_i),
        .sample_i(meas_i.input_power),
        .min_o(min_power)
    );

    // Hysteretic comparator, signed direct-format compare
    always_comb begin
        cmp_above = $signed(meas_i.compared_value) > $signed(hyst_upper_q);
        cmp_below = $signed(meas_i.compared_value) < $signed(hyst_lower_q);
        // rise above, fall below, else hold
        if (cmp_above) begin
            level_d = 1'b1;
        end else if (cmp_below) begin
            level_d = 1'b0;
        end else begin
            level_d = level_q;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            above_upper_flag_q <= 1'b0;
            below_lower_flag_q <= 1'b0;
            level_q <= 1'b0;
        end else if (meas_valid_i) begin
            above_upper_flag_q <= cmp_above;
            below_lower_flag_q <= cmp_below;
            level_q <= level_d;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overcurrent_q <= 1'b0;
        end else begin
            overcurrent_q <= overcurrent_warning_flag_i;
        end
    end

    always_comb begin
        status_byte = 8'h00;
        status_byte[energy_minmax_pkg::ST_BELOW_LOWER] = below_lower_flag_q;
        status_byte[energy_minmax_pkg::ST_ABOVE_UPPER] = above_upper_flag_q;
        status_byte[energy_minmax_pkg::ST_HYST_LEVEL] = level_q;
        status_byte[energy_minmax_pkg::ST_OVERCURRENT] = overcurrent_q;
    end

    // Read mux; whole word is snapshotted so block reads stay coherent
    always_comb begin
        rd_data_d = 64'h0000000000000000;
        rd_len_d = energy_minmax_pkg::LEN_NONE;
        rd_hit_d = 1'b1;
        case (cmd_code_i)
            energy_minmax_pkg::CMD_EXT_INPUT_POWER: begin
                rd_data_d[23:0] = ext_power_q;
                rd_len_d = energy_minmax_pkg::LEN_POWER_EXT;
            end
            energy_minmax_pkg::CMD_FWD_ENERGY_EXT: begin
                rd_data_d[energy_minmax_pkg::ENERGY_LSB +: 24] = fwd_q.value;
                rd_data_d[energy_minmax_pkg::WRAP_LSB +: 16] = fwd_q.wraps;
                rd_data_d[energy_minmax_pkg::SAMPLES_LSB +: 24] = samples_q;
                rd_len_d = energy_minmax_pkg::LEN_ENERGY_EXT;
            end
            energy_minmax_pkg::CMD_REV_ENERGY_EXT: begin
                rd_data_d[energy_minmax_pkg::ENERGY_LSB +: 24] = rev_q.value;
                rd_data_d[energy_minmax_pkg::WRAP_LSB +: 16] = rev_q.wraps;
                rd_data_d[energy_minmax_pkg::SAMPLES_LSB +: 24] = samples_q;
                rd_len_d = energy_minmax_pkg::LEN_ENERGY_EXT;
            end
            energy_minmax_pkg::CMD_AUX_VOLTAGE: begin
                rd_data_d[11:0] = aux_voltage_q;
                rd_len_d = energy_minmax_pkg::LEN_WORD;
            end
            energy_minmax_pkg::CMD_AUX_OV_THRESH: begin
                rd_data_d[11:0] = aux_ov_q;
                rd_len_d = energy_minmax_pkg::LEN_WORD;
            end
            energy_minmax_pkg::CMD_AUX_UV_THRESH: begin
                rd_data_d[11:0] = aux_uv_q;
                rd_len_d = energy_minmax_pkg::LEN_WORD;
            end
            energy_minmax_pkg::CMD_MIN_OUT_CURRENT: begin
                rd_data_d[15:0] = min_current;
                rd_len_d = energy_minmax_pkg::LEN_WORD;
            end
            energy_minmax_pkg::CMD_MIN_INPUT_POWER: begin
                rd_data_d[15:0] = min_power;
                rd_len_d = energy_minmax_pkg::LEN_WORD;
            end
            energy_minmax_pkg::CMD_HYST_LOWER: begin
                rd_data_d[15:0] = hyst_lower_q;
                rd_len_d = energy_minmax_pkg::LEN_WORD;
            end
            energy_minmax_pkg::CMD_HYST_UPPER: begin
                rd_data_d[15:0] = hyst_upper_q;
                rd_len_d = energy_minmax_pkg::LEN_WORD;
            end
            energy_minmax_pkg::CMD_HYST_STATUS: begin
                rd_data_d[7:0] = status_byte;
                rd_len_d = energy_minmax_pkg::LEN_STATUS;
            end
            default: begin
                rd_hit_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_valid_q <= 1'b0;
            rd_unmapped_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_stb_i && rd_hit_d;
            rd_unmapped_q <= rd_stb_i && !rd_hit_d;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_q <= 64'h0000000000000000;
            rd_len_q <= energy_minmax_pkg::LEN_NONE;
        end else if (rd_stb_i) begin
            rd_data_q <= rd_data_d;
            rd_len_q <= rd_len_d;
        end
    end

    assign rd_valid_o = rd_valid_q;
    assign rd_unmapped_o = rd_unmapped_q;
    assign rd_len_o = rd_len_q;
    assign rd_data_o = rd_data_q;
    assign wr_refused_o = wr_refused_q;
    assign hysteretic_output_level_o = level_q;
    assign aux_ov_warn_o = aux_ov_q_flag;
    assign aux_uv_warn_o = aux_uv_q_flag;

endmodule : energy_minmax_hysteresis_regs

//--- tb/energy_minmax_hysteresis_regs_properties.sv
/* Checker for the energy, tracker and hysteresis command bank.
   Assumes it sees only the bank's ports, all on one clock. */
`timescale 1ns/1ps
module energy_minmax_hysteresis_regs_checker (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic meas_valid_i,
    input wire logic overcurrent_warning_flag_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic rd_stb_i,
    input wire logic wr_stb_i,
    input wire logic rd_valid_o,
    input wire logic [3:0] rd_len_o,
    input wire logic [63:0] rd_data_o,
    input wire logic wr_refused_o,
    input wire logic hysteretic_output_level_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_status_layout;
        rd_stb_i && cmd_code_i == 8'hF4 |=> rd_len_o == 4'h1 &&
            rd_data_o[63:3] == {60'h0, $past(overcurrent_warning_flag_i, 2)};
    endproperty
    a_status_layout: assert property (p_status_layout) else $error("status read bad");
    property p_level_mirror;
        rd_stb_i && cmd_code_i == 8'hF4 |=> rd_data_o[2] == $past(hysteretic_output_level_o);
    endproperty
    a_level_mirror: assert property (p_level_mirror) else $error("level bit bad");
    property p_aux_zero;
        rd_stb_i && cmd_code_i == 8'hDD |=> rd_valid_o && rd_len_o == 4'h2 &&
            rd_data_o[63:12] == 52'h0;
    endproperty
    a_aux_zero: assert property (p_aux_zero) else $error("aux read bad");
    property p_energy_len;
        rd_stb_i && cmd_code_i inside {8'hDC, 8'hE5} |=> rd_valid_o && rd_len_o == 4'h8;
    endproperty
    a_energy_len: assert property (p_energy_len) else $error("energy length bad");
    property p_power_len;
        rd_stb_i && cmd_code_i == 8'hDB |=> rd_len_o == 4'h3 && rd_data_o[63:24] == 40'h0;
    endproperty
    a_power_len: assert property (p_power_len) else $error("power read bad");
    property p_level_hold;
        $changed(hysteretic_output_level_o) |-> $past(meas_valid_i);
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("level moved alone");
    property p_ro_refuse;
        wr_stb_i && cmd_code_i inside {8'hDB, 8'hDC, 8'hDD, 8'hE5, 8'hF4} |=> wr_refused_o;
    endproperty
    a_ro_refuse: assert property (p_ro_refuse) else $error("read-only write taken");
    property p_thr_write;
        wr_stb_i && cmd_code_i inside {8'hDE, 8'hDF, 8'hF2, 8'hF3} |=> !wr_refused_o;
    endproperty
    a_thr_write: assert property (p_thr_write) else $error("threshold write refused");
endmodule : energy_minmax_hysteresis_regs_checker

bind energy_minmax_hysteresis_regs energy_minmax_hysteresis_regs_checker u_chk (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .meas_valid_i(meas_valid_i),
    .overcurrent_warning_flag_i(overcurrent_warning_flag_i), .cmd_code_i(cmd_code_i),
    .rd_stb_i(rd_stb_i), .wr_stb_i(wr_stb_i), .rd_valid_o(rd_valid_o), .rd_len_o(rd_len_o),
    .rd_data_o(rd_data_o), .wr_refused_o(wr_refused_o),
    .hysteretic_output_level_o(hysteretic_output_level_o));

//--- tb/pmbus_host_model.sv
/* Host stand-in issuing one decoded command per strobe.
   Assumes the bench calls its tasks; drives on falling edges. */
`timescale 1ns/1ps
module pmbus_host_model (
    input wire logic clk_sys_i,
    output logic [7:0] cmd_code_o,
    output logic rd_stb_o,
    output logic wr_stb_o,
    output logic [15:0] wr_data_o
);
    initial begin
        cmd_code_o = 8'h00;
        rd_stb_o = 1'b0;
        wr_stb_o = 1'b0;
        wr_data_o = 16'h0000;
    end
    task automatic read(input logic [7:0] cmd);
        @(negedge clk_sys_i);
        cmd_code_o = cmd;
        rd_stb_o = 1'b1;
        @(negedge clk_sys_i);
        rd_stb_o = 1'b0;
        // Stale code would hide decode slips
        cmd_code_o = ~cmd;
    endtask : read
    task automatic write(input logic [7:0] cmd, input logic [15:0] data);
        @(negedge clk_sys_i);
        cmd_code_o = cmd;
        wr_data_o = data;
        wr_stb_o = 1'b1;
        @(negedge clk_sys_i);
        wr_stb_o = 1'b0;
        cmd_code_o = ~cmd;
        wr_data_o = ~data;
    endtask : write
endmodule : pmbus_host_model

//--- tb/tb_energy_minmax_hysteresis_regs.sv
/* Self-checking bench for the command bank, unsigned energy variant.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module tb_energy_minmax_hysteresis_regs;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic meas_valid_i = 1'b0;
    energy_minmax_pkg::meas_s meas_i = '0;
    logic energy_valid_i = 1'b0;
    energy_minmax_pkg::energy_inc_s energy_inc_i = '0;
    logic oc_flag = 1'b0;
    logic [7:0] cmd_code;
    logic rd_stb, wr_stb, rd_valid, rd_unmapped, wr_refused, level, ov_warn, uv_warn;
    logic [15:0] wr_data;
    logic [3:0] rd_len;
    logic [63:0] rd_data;
    logic [31:0] seed = 32'h00000026;
    logic [31:0] r;
    logic [63:0] exp_q[$];
    int failures = 0;
    int comparisons = 0;
    logic [7:0] rst_cmd [12] = '{8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hDF, 8'hE3, 8'hE4, 8'hE5,
        8'hF2, 8'hF3, 8'hF4, 8'h00};
    logic [63:0] rst_exp [12] = '{64'h0, 64'h0, 64'h0, 64'h0FFF, 64'h0, 64'h07FF, 64'h7FFF,
        64'h0, 64'h8000, 64'h7FFF, 64'h0, 64'h0};

    always #2 clk_sys_i = ~clk_sys_i;

    energy_minmax_hysteresis_regs uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .meas_valid_i(meas_valid_i), .meas_i(meas_i), .energy_valid_i(energy_valid_i),
        .energy_inc_i(energy_inc_i), .overcurrent_warning_flag_i(oc_flag),
        .cmd_code_i(cmd_code), .rd_stb_i(rd_stb), .wr_stb_i(wr_stb), .wr_data_i(wr_data),
        .rd_valid_o(rd_valid), .rd_unmapped_o(rd_unmapped), .rd_len_o(rd_len),
        .rd_data_o(rd_data), .wr_refused_o(wr_refused), .hysteretic_output_level_o(level),
        .aux_ov_warn_o(ov_warn), .aux_uv_warn_o(uv_warn));
    pmbus_host_model h (.clk_sys_i(clk_sys_i), .cmd_code_o(cmd_code), .rd_stb_o(rd_stb),
        .wr_stb_o(wr_stb), .wr_data_o(wr_data));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] cmd, input logic [63:0] exp);
        exp_q.push_back(exp);
        h.read(cmd);
    endtask : rd
    task automatic meas(input logic [15:0] cmp);
        @(negedge clk_sys_i);
        meas_i.compared_value = cmp;
        meas_valid_i = 1'b1;
        @(negedge clk_sys_i);
        meas_valid_i = 1'b0;
    endtask : meas
    task automatic energy(input logic [23:0] fwd, input logic [23:0] rev);
        @(negedge clk_sys_i);
        energy_inc_i = {fwd, rev};
        energy_valid_i = 1'b1;
        @(negedge clk_sys_i);
        energy_valid_i = 1'b0;
    endtask : energy
    task automatic final_report();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    // Read answers stand one cycle, so one falling edge sees each
    always @(negedge clk_sys_i) begin
        if (rd_valid === 1'b1 || rd_unmapped === 1'b1) begin
            if (exp_q.size() == 0)
                chk(rd_data, ~rd_data);
            else
                chk(rd_data, exp_q.pop_front());
        end
    end

    initial begin
        #20000;
        failures++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        for (int i = 0; i < 12; i++) rd(rst_cmd[i], rst_exp[i]);
        chk({ov_warn, uv_warn, level}, 64'h0);
        h.write(8'hDB, 16'h1234);
        h.write(8'hF4, 16'h00FF);
        rd(8'hDB, 64'h0);
        energy(24'hFFFFFF, 24'h0);
        energy(24'h000001, 24'h0);
        energy(24'h0, 24'h000003);
        rd(8'hDC, {24'h000003, 16'h0001, 24'h000000});
        rd(8'hE5, {24'h000003, 16'h0000, 24'h000003});
        h.write(8'hF2, 16'hFF00);
        h.write(8'hF3, 16'h0100);
        h.write(8'hDE, 16'hF700);
        rd(8'hDE, 64'h0700);
        r = xs();
        meas_i.ext_input_power = r[23:0];
        meas_i.input_power = {1'b1, r[30:16]};
        meas_i.output_current = 16'hFF00;
        meas_i.aux_voltage = 12'h800;
        meas(16'h0200);
        rd(8'hF4, 64'h06);
        chk({ov_warn, uv_warn, level}, 64'h5);
        // Equal to upper: not above, level holds
        meas(16'h0100);
        rd(8'hF4, 64'h04);
        oc_flag = 1'b1;
        meas(16'hFE00);
        rd(8'hF4, 64'h09);
        rd(8'hDB, {40'h0, r[23:0]});
        rd(8'hDD, 64'h0800);
        rd(8'hE3, 64'hFF00);
        rd(8'hE4, {48'h0, 1'b1, r[30:16]});
        h.write(8'hE3, 16'h0005);
        rd(8'hE3, 64'hFF00);
        h.write(8'hE3, 16'h0000);
        rd(8'hE3, 64'h07FF);
        h.write(8'hE4, 16'h0000);
        rd(8'hE4, 64'h7FFF);
        // Mid-run reset: energy clears, live overcurrent returns one edge later
        @(negedge clk_sys_i);
        rst_n_i = 1'b0;
        @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        rd(8'hDC, 64'h0);
        rd(8'hF4, 64'h08);
        repeat (3) @(negedge clk_sys_i);
        chk(exp_q.size(), 64'h0);
        final_report();
    end
endmodule : tb_energy_minmax_hysteresis_regs
